// ---- include/swic_pkg.sv ----
// constants for the sleep/wake and interrupt pin control block
package swic_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_PIN_CTRL_IDX = 8'h2C;
  localparam logic [7:0] REG_SRC_EN_IDX = 8'h2D;
  localparam logic [7:0] REG_SYS_MODE_IDX = 8'h0B;
  localparam logic [7:0] REG_CFG_IDX = 8'h30;
  localparam logic [7:0] REG_EVT_STAT_IDX = 8'h31;
  localparam logic [7:0] REG_EVT_EN_IDX = 8'h32;
  localparam logic [7:0] REG_EVT_CLR_IDX = 8'h33;
  localparam int ADDR_W = 10;
  // pin control register fields
  localparam int PC_FIFO_GATE = 7;
  localparam int PC_WAKE_LO = 2;
  localparam int PC_WAKE_HI = 6;
  localparam int PC_IPOL = 1;
  localparam int PC_DRIVE_STYLE = 0;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_EN_RESET = 8'h00;
  // source bit layout: aslp fifo trans orient pulse ffmt vecm drdy
  localparam int SRC_FUNC_LO = 1;
  localparam int SRC_FUNC_HI = 5;
  localparam int NUM_FUNC = 5;
  // own configuration register fields
  localparam int CFG_ODR_LO = 3;
  localparam int CFG_ODR_HI = 5;
  localparam int CFG_AUTO_SLEEP = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // system mode register fields
  localparam int SM_GATE_ERR = 7;
  localparam int SM_SLEEP = 0;
  // event status bits
  localparam int NUM_EVT = 4;
  localparam int EV_MODE_CHG = 0;
  localparam int EV_FLUSH = 1;
  localparam int EV_GATE_ERR = 2;
  localparam int EV_FUNC_IRQ = 3;
  localparam logic [3:0] EVT_RESET = 4'h0;
  // fifo gate states
  typedef enum logic [1:0] {
    GATE_OPEN = 2'b01,
    GATE_HELD = 2'b10
  } swic_gate_type;
endpackage

// ---- verilog/swic_pin_drv.sv ----
// one interrupt pin driver with polarity and drive style
`timescale 1ns/1ps
`default_nettype none
module swic_pin_drv (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic active,
  input wire logic polarity,
  input wire logic open_drain,
  // pin
  output logic pin_out,
  output logic pin_oe
);
  logic next_out;
  logic next_oe;

  // push-pull always drives; open-drain only pulls low
  assign next_out = open_drain ? 1'b0 : (active ~^ polarity);
  assign next_oe = open_drain ? (active ^ polarity) : 1'b1;

  // register the pin; reset drives inactive level of default mode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= 1'b1;
      pin_oe <= 1'b1;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/swic_top.sv ----
// sleep/wake fifo gating, wake selection and interrupt pin control
// Behaviour
// - gate clear: mode change flushes the fifo
// - gate set: mode change blocks fifo input
// - while held keep contents, drop new samples
// - held and not emptied at sample: gate error
// - gate error stays while fifo not emptied
// - emptying fifo clears error, reopens input
// - any data rate change flushes the fifo
// - transient wake bit keeps detector in sleep
// - orientation wake bit keeps detector in sleep
// - pulse wake bit keeps detector in sleep
// - freefall/motion wake bit keeps detector in sleep
// - magnitude wake bit keeps detector in sleep
// - polarity bit sets asserted pin level
// - style bit selects push-pull or open-drain
// - auto-sleep transitions reset function counters
// - per-function enable gates flag onto pins
// - sources on one pin are ORed
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module swic_top #(
  parameter logic [7:0] PIN_A_MASK = 8'hFF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [swic_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // system state and fifo
  input wire logic sleep_mode,
  input wire logic sample_valid,
  input wire logic fifo_empty,
  output logic sample_write,
  output logic fifo_flush,
  output logic fifo_accept,
  output logic counter_reset,
  // detection functions
  input wire logic [7:0] src_flags,
  output logic [swic_pkg::NUM_FUNC-1:0] func_run,
  // interrupt pins and block interrupt
  output logic irq_pin_a_out,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe,
  output logic irq
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [7:0] pin_ctrl;
  logic [7:0] src_en;
  logic [7:0] cfg;
  logic [swic_pkg::NUM_EVT-1:0] evt_stat;
  logic [swic_pkg::NUM_EVT-1:0] evt_en;
  logic sleep_prev;
  logic [2:0] odr_prev;
  logic gate_err;
  swic_pkg::swic_gate_type gate_state;
  swic_pkg::swic_gate_type next_gate_state;

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // bus decode: one wait state, access completes when waitrequest low
  wire [7:0] reg_idx = address[swic_pkg::ADDR_W-1:2];
  wire bus_req = read | write;
  wire bus_done = bus_req & ~waitrequest;
  wire wr_ok = write & bus_done & byteenable[0];
  wire wr_pin_ctrl = wr_ok & (reg_idx == swic_pkg::REG_PIN_CTRL_IDX);
  wire wr_src_en = wr_ok & (reg_idx == swic_pkg::REG_SRC_EN_IDX);
  wire wr_cfg = wr_ok & (reg_idx == swic_pkg::REG_CFG_IDX);
  wire wr_evt_en = wr_ok & (reg_idx == swic_pkg::REG_EVT_EN_IDX);
  wire wr_evt_clr = wr_ok & (reg_idx == swic_pkg::REG_EVT_CLR_IDX);

  // control fields
  wire fifo_gate = pin_ctrl[swic_pkg::PC_FIFO_GATE];
  wire [swic_pkg::NUM_FUNC-1:0] wake_bits = pin_ctrl[swic_pkg::PC_WAKE_HI:swic_pkg::PC_WAKE_LO];
  wire ipol = pin_ctrl[swic_pkg::PC_IPOL];
  wire irq_pin_drive_style = pin_ctrl[swic_pkg::PC_DRIVE_STYLE];
  wire [2:0] odr = cfg[swic_pkg::CFG_ODR_HI:swic_pkg::CFG_ODR_LO];
  wire auto_sleep = cfg[swic_pkg::CFG_AUTO_SLEEP];

  // system mode register: gate error and current mode
  wire [7:0] system_mode_register = {gate_err, 6'h00, sleep_mode};

  // read data selection; unmapped addresses read zero
  wire [7:0] rd_byte =
    (reg_idx == swic_pkg::REG_PIN_CTRL_IDX) ? pin_ctrl :
    (reg_idx == swic_pkg::REG_SRC_EN_IDX) ? src_en :
    (reg_idx == swic_pkg::REG_SYS_MODE_IDX) ? system_mode_register :
    (reg_idx == swic_pkg::REG_CFG_IDX) ? cfg :
    (reg_idx == swic_pkg::REG_EVT_STAT_IDX) ? {4'h0, evt_stat} :
    (reg_idx == swic_pkg::REG_EVT_EN_IDX) ? {4'h0, evt_en} : 8'h00;

  // waitrequest drops one cycle after a request appears
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      waitrequest <= ~(bus_req & waitrequest);
      if (read & waitrequest)
        readdata <= {24'h00_0000, rd_byte};
    end
  end

  // software registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_ctrl <= swic_pkg::PIN_CTRL_RESET;
      src_en <= swic_pkg::SRC_EN_RESET;
      cfg <= swic_pkg::CFG_RESET;
      evt_en <= swic_pkg::EVT_RESET;
    end
    else
    begin
      if (wr_pin_ctrl)
        pin_ctrl <= writedata[7:0];
      if (wr_src_en)
        src_en <= writedata[7:0];
      if (wr_cfg)
        cfg <= writedata[7:0];
      if (wr_evt_en)
        evt_en <= writedata[swic_pkg::NUM_EVT-1:0];
    end
  end

  // transitions of mode and data rate
  wire mode_chg = sleep_mode ^ sleep_prev;
  wire odr_chg = odr != odr_prev;
  wire held = gate_state == swic_pkg::GATE_HELD;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_prev <= 1'b0;
      odr_prev <= 3'h0;
    end
    else
    begin
      sleep_prev <= sleep_mode;
      odr_prev <= odr;
    end
  end

  // fifo gate state: hold after a mode change until the host empties it
  always_comb
  begin
    next_gate_state = gate_state;
    case (gate_state)
      swic_pkg::GATE_OPEN:
        if (mode_chg & fifo_gate)
          next_gate_state = swic_pkg::GATE_HELD;
      swic_pkg::GATE_HELD:
        if (fifo_empty)
          next_gate_state = swic_pkg::GATE_OPEN;
      default:
        next_gate_state = swic_pkg::GATE_OPEN;
    endcase
  end

  // flush requests and held-sample handling
  wire flush_req = (mode_chg & ~fifo_gate) | odr_chg;
  wire held_sample = held & sample_valid & ~fifo_empty;
  wire next_gate_err = held & ~fifo_empty & (gate_err | sample_valid);
  wire next_accept = next_gate_state == swic_pkg::GATE_OPEN;

  // gate registers and fifo controls
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_state <= swic_pkg::GATE_OPEN;
      gate_err <= 1'b0;
      fifo_flush <= 1'b0;
      fifo_accept <= 1'b1;
      sample_write <= 1'b0;
      counter_reset <= 1'b0;
    end
    else
    begin
      gate_state <= next_gate_state;
      gate_err <= next_gate_err;
      fifo_flush <= flush_req;
      fifo_accept <= next_accept;
      sample_write <= sample_valid & ~held & ~(mode_chg & fifo_gate);
      counter_reset <= mode_chg & auto_sleep;
    end
  end

  // sleep gating of the detection functions
  wire [swic_pkg::NUM_FUNC-1:0] next_run = wake_bits | {swic_pkg::NUM_FUNC{~sleep_mode}};
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      func_run <= {swic_pkg::NUM_FUNC{1'b1}};
    else
      func_run <= next_run;
  end

  // flags from sleeping functions are dropped, then enables gate each source
  wire [7:0] run_mask = {2'b11, func_run, 1'b1};
  wire [7:0] live_flags = src_flags & run_mask;
  wire [7:0] routed = live_flags & src_en;
  wire pin_a_active = |(routed & PIN_A_MASK);
  wire pin_b_active = |(routed & ~PIN_A_MASK);

  // pin drivers
  swic_pin_drv u_pin_a (
    .clock(clock),
    .rst_n(rst_n),
    .active(pin_a_active),
    .polarity(ipol),
    .open_drain(irq_pin_drive_style),
    .pin_out(irq_pin_a_out),
    .pin_oe(irq_pin_a_oe)
  );
  swic_pin_drv u_pin_b (
    .clock(clock),
    .rst_n(rst_n),
    .active(pin_b_active),
    .polarity(ipol),
    .open_drain(irq_pin_drive_style),
    .pin_out(irq_pin_b_out),
    .pin_oe(irq_pin_b_oe)
  );

  // block events: sticky status, set wins over clear
  wire [swic_pkg::NUM_EVT-1:0] evt_set = {pin_a_active | pin_b_active, held_sample & ~gate_err,
    flush_req, mode_chg};
  wire [swic_pkg::NUM_EVT-1:0] evt_clr = wr_evt_clr ? writedata[swic_pkg::NUM_EVT-1:0] : 4'h0;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_stat <= swic_pkg::EVT_RESET;
      irq <= 1'b0;
    end
    else
    begin
      evt_stat <= (evt_stat & ~evt_clr) | evt_set;
      irq <= |(((evt_stat & ~evt_clr) | evt_set) & evt_en);
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_held_change;
    mode_chg && fifo_gate && !held;
  endsequence
  sequence s_held_not_empty;
    held && !fifo_empty;
  endsequence

  a_flush_on_change: assert property (mode_chg && !fifo_gate |=> fifo_flush)
    else $error("no flush after mode change with gate clear");
  a_hold_on_change: assert property (s_held_change |=> held && !fifo_accept)
    else $error("input not held after mode change with gate set");
  a_drop_held: assert property (s_held_change ##1 sample_valid |=> !sample_write)
    else $error("sample written while input held");
  a_gate_err_set: assert property (s_held_not_empty and sample_valid |=> gate_err)
    else $error("gate error not raised");
  a_gate_err_keep: assert property (gate_err && !fifo_empty |=> gate_err [*1] ##0 held)
    else $error("gate error cleared before fifo emptied");
  a_gate_release: assert property (held && fifo_empty |=> !gate_err && fifo_accept && !held)
    else $error("gate not released after fifo emptied");
  a_odr_flush: assert property (odr_chg |=> fifo_flush && !odr_chg)
    else $error("no flush after data rate change");
  a_sleep_run: assert property (sleep_mode && $stable(pin_ctrl) |=> func_run == $past(wake_bits))
    else $error("sleep function gating wrong");
  a_pin_level: assert property (!irq_pin_drive_style && $stable(ipol) ##1 $stable(pin_ctrl)
    |=> irq_pin_a_out == ($past(pin_a_active) ~^ $past(ipol)))
    else $error("pin level does not follow polarity");
  a_open_drain: assert property (##1 $past(irq_pin_drive_style) |-> !irq_pin_a_out && !irq_pin_b_out)
    else $error("open-drain pin driven high");
  a_count_reset: assert property (mode_chg && auto_sleep |=> counter_reset)
    else $error("counters not reset on transition");
  // func_run is registered, so the mask is only settled one cycle into sleep and after reset
  a_src_gate: assert property (sleep_mode && $past(sleep_mode) && $past(rst_n) && $stable(wake_bits)
    |-> (live_flags[5:1] & ~wake_bits) == 5'h00)
    else $error("sleeping function flag reached pins");
endmodule
`default_nettype wire

// ---- bench/swic_host_model.sv ----
// host view of the two interrupt lines with an external pull-up
`timescale 1ns/1ps
`default_nettype none
module swic_host_model (
  // pins from the block
  input wire logic out_a,
  input wire logic oe_a,
  input wire logic out_b,
  input wire logic oe_b,
  input wire logic polarity,
  // resolved lines and asserted flags
  output logic line_a,
  output logic line_b,
  output logic hit_a,
  output logic hit_b
);
  // the pull-up holds a released line high
  assign line_a = oe_a ? out_a : 1'b1;
  assign line_b = oe_b ? out_b : 1'b1;
  // a line at the polarity level counts as asserted
  assign hit_a = (line_a == polarity);
  assign hit_b = (line_b == polarity);
endmodule
`default_nettype wire

// ---- bench/sleep_wake_interrupt_control_tb.sv ----
// self-checking bench for the sleep/wake interrupt control block
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_interrupt_control_tb;
  // clock, reset and bus
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  // fifo side, functions and pins
  logic sleep_mode = 1'b0;
  logic sample_valid = 1'b0;
  logic fifo_empty = 1'b0;
  logic [7:0] src_flags = 8'h00;
  logic sample_write, fifo_flush, fifo_accept, counter_reset, irq;
  logic [4:0] func_run;
  logic pa_out, pa_oe, pb_out, pb_oe, line_a, line_b, hit_a, hit_b;
  logic pol = 1'b0;
  logic [7:0] q;
  logic [7:0] nfl = 8'h00, nsw = 8'h00, ncr = 8'h00;
  int fail_count = 0, samples_checked = 0, cyc = 0;

  // clock
  always #25 clock = ~clock;

  swic_top #(.PIN_A_MASK(8'h0F)) DUT (.clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_mode(sleep_mode), .sample_valid(sample_valid),
    .fifo_empty(fifo_empty), .sample_write(sample_write), .fifo_flush(fifo_flush),
    .fifo_accept(fifo_accept), .counter_reset(counter_reset), .src_flags(src_flags),
    .func_run(func_run), .irq_pin_a_out(pa_out), .irq_pin_a_oe(pa_oe), .irq_pin_b_out(pb_out),
    .irq_pin_b_oe(pb_oe), .irq(irq));

  swic_host_model HOST (.out_a(pa_out), .oe_a(pa_oe), .out_b(pb_out), .oe_b(pb_oe),
    .polarity(pol), .line_a(line_a), .line_b(line_b), .hit_a(hit_a), .hit_b(hit_b));

  // pulse counters and hang limit
  always @(posedge clock)
  begin
    nfl <= nfl + fifo_flush;
    nsw <= nsw + sample_write;
    ncr <= ncr + counter_reset;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic ck(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= ~w;
    write <= w;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    ck("register", e, q);
  endtask

  task automatic t_reset;
    rd(swic_pkg::REG_PIN_CTRL_IDX, 8'h00);
    rd(swic_pkg::REG_SRC_EN_IDX, 8'h00);
    rd(8'h3F, 8'h00);
    ck("idle line", 8'h01, {7'h00, line_a});
    $display("test reset done");
  endtask

  task automatic t_pins;
    logic [7:0] fl [3] = '{8'h04, 8'h0A, 8'h10};
    logic [7:0] ex [3] = '{8'h00, 8'h02, 8'h01};
    wr(swic_pkg::REG_SRC_EN_IDX, 8'h1A);
    for (int k = 0; k < 4; k++)
    begin
      pol = k[1];
      wr(swic_pkg::REG_PIN_CTRL_IDX, 8'(k));
      for (int t = 0; t < 3; t++)
      begin
        src_flags <= fl[t];
        tick(3);
        ck("pins", ex[t], {6'h00, hit_a, hit_b});
      end
    end
    src_flags <= 8'h00;
    $display("test pins done");
  endtask

  task automatic t_wake;
    pol = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(swic_pkg::REG_PIN_CTRL_IDX, 8'h04 << i);
      sleep_mode <= 1'b1;
      tick(3);
      ck("run", 8'h01 << i, {3'h0, func_run});
      sleep_mode <= 1'b0;
      tick(3);
      ck("run", 8'h1F, {3'h0, func_run});
    end
    sleep_mode <= 1'b1;
    src_flags <= 8'h08;
    tick(3);
    ck("sleep pin", 8'h00, {7'h00, hit_a});
    wr(swic_pkg::REG_PIN_CTRL_IDX, 8'h04);
    src_flags <= 8'h02;
    tick(3);
    ck("sleep pin", 8'h01, {7'h00, hit_a});
    sleep_mode <= 1'b0;
    src_flags <= 8'h00;
    tick(3);
    $display("test wake done");
  endtask

  task automatic t_flush;
    logic [7:0] f0;
    f0 = nfl;
    wr(swic_pkg::REG_PIN_CTRL_IDX, 8'h00);
    sleep_mode <= 1'b1;
    tick(4);
    sleep_mode <= 1'b0;
    tick(4);
    ck("flush", f0 + 8'h02, nfl);
    wr(swic_pkg::REG_CFG_IDX, 8'h08);
    tick(3);
    ck("flush", f0 + 8'h03, nfl);
    wr(swic_pkg::REG_CFG_IDX, 8'h0C);
    sleep_mode <= 1'b1;
    tick(4);
    ck("flush", f0 + 8'h04, nfl);
    ck("counter", 8'h01, ncr);
    $display("test flush done");
  endtask

  task automatic t_gate;
    logic [7:0] s0, f0;
    s0 = nsw;
    wr(swic_pkg::REG_PIN_CTRL_IDX, 8'h80);
    f0 = nfl;
    sleep_mode <= 1'b0;
    tick(2);
    ck("accept", 8'h00, {7'h00, fifo_accept});
    sample_valid <= 1'b1;
    tick(1);
    sample_valid <= 1'b0;
    tick(3);
    ck("writes", s0, nsw);
    ck("flush", f0, nfl);
    rd(swic_pkg::REG_SYS_MODE_IDX, 8'h80);
    tick(10);
    rd(swic_pkg::REG_SYS_MODE_IDX, 8'h80);
    fifo_empty <= 1'b1;
    tick(3);
    ck("accept", 8'h01, {7'h00, fifo_accept});
    rd(swic_pkg::REG_SYS_MODE_IDX, 8'h00);
    sample_valid <= 1'b1;
    tick(1);
    sample_valid <= 1'b0;
    tick(3);
    ck("writes", s0 + 8'h01, nsw);
    $display("test gate done");
  endtask

  task automatic t_irq;
    wr(swic_pkg::REG_PIN_CTRL_IDX, 8'h00);
    wr(swic_pkg::REG_EVT_CLR_IDX, 8'h0F);
    rd(swic_pkg::REG_EVT_STAT_IDX, 8'h00);
    sleep_mode <= 1'b1;
    tick(3);
    rd(swic_pkg::REG_EVT_STAT_IDX, 8'h03);
    ck("irq", 8'h00, {7'h00, irq});
    wr(swic_pkg::REG_EVT_EN_IDX, 8'h01);
    tick(2);
    ck("irq", 8'h01, {7'h00, irq});
    wr(swic_pkg::REG_EVT_CLR_IDX, 8'h01);
    tick(2);
    ck("irq", 8'h00, {7'h00, irq});
    wr(swic_pkg::REG_EVT_STAT_IDX, 8'hFF);
    rd(swic_pkg::REG_EVT_STAT_IDX, 8'h02);
    rd(swic_pkg::REG_EVT_CLR_IDX, 8'h00);
    $display("test irq done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    tick(3);
    rstn <= 1'b1;
    tick(3);
    t_reset();
    t_pins();
    t_wake();
    t_flush();
    t_gate();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
